// *** rtl/axis_position_limit_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "axis_consts.svh"

// Notes on behaviour
// - Positioning range spans -268435456 to 268435455 user units.
// - Only absolute point-to-point moves are refused past the range.
// - Position leaving the range drops the reference-valid flag.
// - Overtravelling relative move zeroes position at start, drops reference.
// - Current position is readable as a parameter.
// - Software limits act only while the reference is valid.
// - Enable code: 0 none, 1 positive, 2 negative, 3 both; default 0.
// - Software limits are compared against zero-relative position.
// - Limit written outside the positioning range is stored as 7fffffff (positive) or 80000000 (negative).
// - Software limit trigger sets bit 2 of the latched word.
// - Active hardware limit stops motion toward that switch and is reported.
// - Hardware limit config: 0 ignore, 1 active low, 2 active high.
// - Reference switch polarity 1 or 2, evaluated only during homing.
// - Jog can move out of a limit region back into range.
module axis_position_limit_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic param_write,
    input wire logic param_read,
    input wire logic [15:0] param_addr,
    input wire logic [31:0] param_wdata,
    output logic [31:0] param_rdata,
    output logic param_ready,
    input wire axis_pkg::op_mode_e mode,
    input wire logic motion_active,
    input wire logic move_dir,
    input wire logic move_start,
    input wire logic move_absolute,
    input wire logic [31:0] move_target,
    output logic move_refused,
    input wire logic step_valid,
    input wire logic step_dir,
    input wire logic homing_active,
    input wire logic home_set,
    input wire logic [31:0] home_value,
    input wire logic positive_hw_limit_input,
    input wire logic negative_hw_limit_input,
    input wire logic ref_switch_input,
    output logic ref_switch_active,
    output logic ref_valid,
    output logic [31:0] position,
    output logic positive_hw_hit,
    output logic negative_hw_hit,
    output logic soft_limit_hit,
    output logic motor_stop
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic out_of_range(input logic [32:0] p);
        out_of_range = ($signed(p) < $signed(`POS_MIN)) ||
                       ($signed(p) > $signed(`POS_MAX));
    endfunction : out_of_range

    function automatic logic switch_active(input logic [15:0] cfg,
                                           input logic pin);
        switch_active = ((cfg == `CFG_NC) && !pin) ||
                        ((cfg == `CFG_NO) && pin);
    endfunction : switch_active

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    axis_pkg::monitor_state_s st;
    axis_pkg::monitor_state_s next_st;

    logic [32:0] pos_ext;
    logic [32:0] target_ext;
    logic [32:0] rel_sum;
    logic [32:0] step_sum;
    logic abs_over;
    logic rel_over;
    logic soft_pos_on;
    logic soft_neg_on;
    logic soft_pos_block;
    logic soft_neg_block;
    logic pos_block;
    logic neg_block;
    logic pp_mode;

    always_comb begin
        pos_ext = {st.position[31], st.position};
        target_ext = {move_target[31], move_target};
        rel_sum = pos_ext + target_ext;
        step_sum = step_dir ? pos_ext + 33'h000000001
                            : pos_ext - 33'h000000001;
        pp_mode = (mode == axis_pkg::MODE_PROFILE_POSITION);
        abs_over = pp_mode && move_start && move_absolute &&
                   out_of_range(target_ext);
        rel_over = pp_mode && move_start && !move_absolute &&
                   out_of_range(rel_sum);
    end

    // ------------------------------------------------------------
    // Limit evaluation
    // ------------------------------------------------------------
    always_comb begin
        // Only bits 0 and 1 of the enable code carry meaning.
        soft_pos_on = st.ref_valid &&
                      st.soft_en[`SWEN_POS_BIT];
        soft_neg_on = st.ref_valid &&
                      st.soft_en[`SWEN_NEG_BIT];
        // Position is already relative to the homed zero point.
        soft_pos_block = soft_pos_on &&
            ($signed(st.position) >= $signed(st.soft_pos));
        soft_neg_block = soft_neg_on &&
            ($signed(st.position) <= $signed(st.soft_neg));
        positive_hw_hit = switch_active(st.positive_hw_limit_input_cfg,
            positive_hw_limit_input);
        negative_hw_hit = switch_active(st.negative_hw_limit_input_cfg,
            negative_hw_limit_input);
        pos_block = positive_hw_hit || soft_pos_block;
        neg_block = negative_hw_hit || soft_neg_block;
        soft_limit_hit = motion_active &&
            ((move_dir && soft_pos_block) ||
             (!move_dir && soft_neg_block));
        // Blocking only the direction into the switch lets a jog
        // leave the limit region; any mode may back out the same way.
        motor_stop = motion_active &&
            ((move_dir && pos_block) ||
             (!move_dir && neg_block));
        ref_switch_active = homing_active &&
            switch_active(st.ref_pol, ref_switch_input);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.refused = abs_over;
        next_st.ready = param_write || param_read;

        if (home_set) begin
            next_st.position = home_value;
            next_st.ref_valid =
                !out_of_range({home_value[31], home_value});
        end else if (rel_over) begin
            next_st.position = 32'h00000000;
            next_st.ref_valid = 1'b0;
        end else if (step_valid) begin
            next_st.position = step_sum[31:0];
            if (out_of_range(step_sum)) begin
                next_st.ref_valid = 1'b0;
            end
        end

        if (param_write) begin
            unique case (param_addr)
                `ADDR_SOFT_EN: next_st.soft_en = param_wdata[15:0];
                `ADDR_SOFT_POS: begin
                    next_st.soft_pos = out_of_range(
                        {param_wdata[31], param_wdata}) ?
                        `USER_MAX : param_wdata;
                end
                `ADDR_SOFT_NEG: begin
                    next_st.soft_neg = out_of_range(
                        {param_wdata[31], param_wdata}) ?
                        `USER_MIN : param_wdata;
                end
                `ADDR_REF_POL: next_st.ref_pol = param_wdata[15:0];
                `ADDR_NEGATIVE_HW_LIMIT_INPUT_CFG: next_st.negative_hw_limit_input_cfg = param_wdata[15:0];
                `ADDR_POSITIVE_HW_LIMIT_INPUT_CFG: next_st.positive_hw_limit_input_cfg = param_wdata[15:0];
                `ADDR_LATCHED: begin
                    next_st.latched = st.latched & ~param_wdata;
                end
                default: begin
                end
            endcase
        end

        // Setting after the clear means a new event always survives.
        if (soft_limit_hit) begin
            next_st.latched[`LATCH_SW_BIT] = 1'b1;
        end
        if (motion_active && (positive_hw_hit || negative_hw_hit)) begin
            next_st.latched[`LATCH_HW_BIT] = 1'b1;
        end

        next_st.rdata = 32'h00000000;
        if (param_read) begin
            unique case (param_addr)
                `ADDR_SOFT_EN: next_st.rdata = {16'h0000, st.soft_en};
                `ADDR_SOFT_POS: next_st.rdata = st.soft_pos;
                `ADDR_SOFT_NEG: next_st.rdata = st.soft_neg;
                `ADDR_REF_POL: next_st.rdata = {16'h0000, st.ref_pol};
                `ADDR_NEGATIVE_HW_LIMIT_INPUT_CFG: next_st.rdata = {16'h0000, st.negative_hw_limit_input_cfg};
                `ADDR_POSITIVE_HW_LIMIT_INPUT_CFG: next_st.rdata = {16'h0000, st.positive_hw_limit_input_cfg};
                `ADDR_POSITION: next_st.rdata = st.position;
                `ADDR_LATCHED: next_st.rdata = st.latched;
                default: next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.position <= 32'h00000000;
            st.ref_valid <= 1'b0;
            st.soft_en <= `RST_SOFT_EN;
            st.soft_pos <= `RST_SOFT_POS;
            st.soft_neg <= `RST_SOFT_NEG;
            st.ref_pol <= `RST_REF_POL;
            st.negative_hw_limit_input_cfg <= `RST_NEGATIVE_HW_LIMIT_INPUT_CFG;
            st.positive_hw_limit_input_cfg <= `RST_POSITIVE_HW_LIMIT_INPUT_CFG;
            st.latched <= 32'h00000000;
            st.rdata <= 32'h00000000;
            st.ready <= 1'b0;
            st.refused <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign param_rdata = st.rdata;
    assign param_ready = st.ready;
    assign move_refused = st.refused;
    assign ref_valid = st.ref_valid;
    assign position = st.position;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seq_rel_over;
        pp_mode && move_start && !move_absolute && !home_set &&
        out_of_range(rel_sum);
    endsequence

    sequence seq_abs_over;
        pp_mode && move_start && move_absolute &&
        out_of_range(target_ext) && !home_set && !step_valid &&
        !rel_over;
    endsequence

    sequence seq_soft_write(logic [15:0] a);
        param_write && param_addr == a &&
        out_of_range({param_wdata[31], param_wdata});
    endsequence

    a_range_ref_loss: assert property (
        out_of_range(pos_ext) |-> !st.ref_valid)
        else $error("reference valid outside range");

    a_abs_refused: assert property (
        seq_abs_over |=> move_refused && $stable(st.position))
        else $error("absolute overtravel not refused");

    a_rel_zero: assert property (
        seq_rel_over |=> st.position == 32'h00000000 && !st.ref_valid)
        else $error("relative overtravel not zeroed");

    a_soft_gate: assert property (
        !st.ref_valid |-> !soft_limit_hit)
        else $error("soft limit without reference");

    a_soft_latch: assert property (
        soft_limit_hit |=> st.latched[`LATCH_SW_BIT] &&
            st.latched[`LATCH_SW_BIT] == $past(soft_limit_hit))
        else $error("soft limit not latched");

    a_pos_clamp: assert property (
        seq_soft_write(`ADDR_SOFT_POS) |=> st.soft_pos == `USER_MAX)
        else $error("positive limit not clamped");

    a_neg_clamp: assert property (
        seq_soft_write(`ADDR_SOFT_NEG) |=> st.soft_neg == `USER_MIN)
        else $error("negative limit not clamped");

    a_hw_stop: assert property (
        motion_active && move_dir && positive_hw_hit |-> motor_stop)
        else $error("hardware limit did not stop");

    a_ref_gate: assert property (
        !homing_active |-> !ref_switch_active)
        else $error("reference switch outside homing");

    a_jog_away: assert property (
        mode == axis_pkg::MODE_JOG && motion_active && !move_dir &&
        !neg_block |-> !motor_stop)
        else $error("jog away from limit blocked");

    // A home load or a zeroing move may land on the read edge, so the
    // returned word is the position held when the read was taken.
    a_read_pos: assert property (
        param_read && param_addr == `ADDR_POSITION && !step_valid
        |=> param_ready && param_rdata == $past(st.position))
        else $error("position read mismatch");

endmodule : axis_position_limit_monitor

`default_nettype wire

// *** rtl/axis_consts.svh ***
`ifndef AXIS_CONSTS_SVH
`define AXIS_CONSTS_SVH

// ----------------------------------------------------------------
// Parameter addresses
// ----------------------------------------------------------------
`define ADDR_SOFT_EN 16'h0606
`define ADDR_SOFT_POS 16'h0608
`define ADDR_SOFT_NEG 16'h060a
`define ADDR_REF_POL 16'h061c
`define ADDR_NEGATIVE_HW_LIMIT_INPUT_CFG 16'h061e
`define ADDR_POSITIVE_HW_LIMIT_INPUT_CFG 16'h0620
`define ADDR_POSITION 16'h0700
`define ADDR_LATCHED 16'h0702

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SOFT_EN 16'h0000
`define RST_SOFT_POS 32'h7fffffff
`define RST_SOFT_NEG 32'h80000000
`define RST_REF_POL 16'h0001
`define RST_NEGATIVE_HW_LIMIT_INPUT_CFG 16'h0001
`define RST_POSITIVE_HW_LIMIT_INPUT_CFG 16'h0001

// ----------------------------------------------------------------
// Ranges and field codes
// ----------------------------------------------------------------
`define POS_MIN 33'h1f0000000
`define POS_MAX 33'h00fffffff
`define USER_MAX 32'h7fffffff
`define USER_MIN 32'h80000000
`define SWEN_POS_BIT 0
`define SWEN_NEG_BIT 1
`define LATCH_HW_BIT 1
`define LATCH_SW_BIT 2
`define CFG_NC 16'h0001
`define CFG_NO 16'h0002

`endif

// *** rtl/axis_pkg.sv ***
package axis_pkg;

    typedef enum logic [1:0] {
        MODE_PROFILE_POSITION,
        MODE_JOG,
        MODE_OTHER
    } op_mode_e;

    typedef struct packed {
        logic [31:0] position;
        logic ref_valid;
        logic [15:0] soft_en;
        logic [31:0] soft_pos;
        logic [31:0] soft_neg;
        logic [15:0] ref_pol;
        logic [15:0] negative_hw_limit_input_cfg;
        logic [15:0] positive_hw_limit_input_cfg;
        logic [31:0] latched;
        logic [31:0] rdata;
        logic ready;
        logic refused;
    } monitor_state_s;

endpackage : axis_pkg

// *** verification/axis_switch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module axis_switch_model (
    input wire logic p_press,
    input wire logic n_press,
    input wire logic r_press,
    input wire logic nc,
    output logic p_pin,
    output logic n_pin,
    output logic r_pin
);
    // Closed contacts open when pressed, so a cut wire reads as pressed.
    assign p_pin = p_press ^ nc;
    assign n_pin = n_press ^ nc;
    assign r_pin = r_press ^ nc;
endmodule : axis_switch_model
`default_nettype wire

// *** verification/axis_position_limit_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "axis_consts.svh"
module axis_position_limit_monitor_tb;
    logic clk = 1'h0, rst = 1'h1, pw = 1'h0, pr = 1'h0, ms = 1'h0;
    logic mabs = 1'h0, moving = 1'h0, dir = 1'h0, sv = 1'h0, sd = 1'h0;
    logic homing = 1'h0, hset = 1'h0, p_p = 1'h0, n_p = 1'h0, r_p = 1'h0;
    logic nc = 1'h1, ready, refused, lp, ln, lr, ref_act, refv, hit_p;
    logic hit_n, soft_hit, stop;
    logic [15:0] addr = 16'h0;
    logic [31:0] wdata = 32'h0, mtgt = 32'h0, hval = 32'h0, rdata, pos, rq;
    axis_pkg::op_mode_e mode = axis_pkg::MODE_PROFILE_POSITION;
    int n_errors = 0, samples_checked = 0;

    axis_position_limit_monitor dut_u (.clk(clk), .rst(rst),
        .param_write(pw), .param_read(pr), .param_addr(addr),
        .param_wdata(wdata), .param_rdata(rdata), .param_ready(ready),
        .mode(mode), .motion_active(moving), .move_dir(dir),
        .move_start(ms), .move_absolute(mabs), .move_target(mtgt),
        .move_refused(refused), .step_valid(sv), .step_dir(sd),
        .homing_active(homing), .home_set(hset), .home_value(hval),
        .positive_hw_limit_input(lp), .negative_hw_limit_input(ln),
        .ref_switch_input(lr), .ref_switch_active(ref_act),
        .ref_valid(refv), .position(pos), .positive_hw_hit(hit_p),
        .negative_hw_hit(hit_n), .soft_limit_hit(soft_hit),
        .motor_stop(stop));
    axis_switch_model sw_u (.p_press(p_p), .n_press(n_p), .r_press(r_p),
        .nc(nc), .p_pin(lp), .n_pin(ln), .r_pin(lr));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic bus(logic wr, logic [15:0] a, logic [31:0] d);
        int n;
        tick();
        addr = a;
        wdata = d;
        {pw, pr} = {wr, !wr};
        tick();
        {pw, pr} = 2'h0;
        for (n = 0; n < 4 && ready !== 1'h1; n++) tick();
        if (n == 4) begin
            n_errors++;
            results();
        end
        rq = rdata;
    endtask : bus

    task automatic rd_chk(string what, logic [15:0] a, logic [31:0] exp);
        bus(1'h0, a, 32'h0);
        check(what, rq, exp);
    endtask : rd_chk

    task automatic pulse(ref logic s);
        tick();
        s = 1'h1;
        tick();
        s = 1'h0;
    endtask : pulse

    task automatic t_regs();
        rd_chk("soft_en", `ADDR_SOFT_EN, 32'h0);
        rd_chk("soft_pos", `ADDR_SOFT_POS, 32'h7fffffff);
        rd_chk("soft_neg", `ADDR_SOFT_NEG, 32'h80000000);
        rd_chk("ref_pol", `ADDR_REF_POL, 32'h1);
        rd_chk("negative_hw_limit_input_cfg", `ADDR_NEGATIVE_HW_LIMIT_INPUT_CFG, 32'h1);
        rd_chk("positive_hw_limit_input_cfg", `ADDR_POSITIVE_HW_LIMIT_INPUT_CFG, 32'h1);
        rd_chk("unmapped", 16'h0800, 32'h0);
        bus(1'h1, `ADDR_SOFT_POS, 32'h0fffffff);
        rd_chk("pos_keep", `ADDR_SOFT_POS, 32'h0fffffff);
        bus(1'h1, `ADDR_SOFT_POS, 32'h10000000);
        rd_chk("pos_clip", `ADDR_SOFT_POS, 32'h7fffffff);
        bus(1'h1, `ADDR_SOFT_NEG, 32'hf0000000);
        rd_chk("neg_keep", `ADDR_SOFT_NEG, 32'hf0000000);
        bus(1'h1, `ADDR_SOFT_NEG, 32'hefffffff);
        rd_chk("neg_clip", `ADDR_SOFT_NEG, 32'h80000000);
    endtask : t_regs

    task automatic t_range();
        hval = 32'h0ffffffe;
        pulse(hset);
        sd = 1'h1;
        pulse(sv);
        check("ref_top", refv, 32'h1);
        pulse(sv);
        check("ref_over", refv, 32'h0);
        rd_chk("position", `ADDR_POSITION, 32'h10000000);
        hval = 32'hf0000001;
        pulse(hset);
        sd = 1'h0;
        pulse(sv);
        check("ref_bottom", refv, 32'h1);
        pulse(sv);
        check("ref_under", refv, 32'h0);
        rd_chk("pos_under", `ADDR_POSITION, 32'hefffffff);
    endtask : t_range

    task automatic t_moves();
        hval = 32'h5;
        pulse(hset);
        mabs = 1'h1;
        mtgt = 32'h10000000;
        pulse(ms);
        check("abs_pp", refused, 32'h1);
        mode = axis_pkg::MODE_JOG;
        pulse(ms);
        check("abs_jog", refused, 32'h0);
        mode = axis_pkg::MODE_OTHER;
        pulse(ms);
        check("abs_other", refused, 32'h0);
        mode = axis_pkg::MODE_PROFILE_POSITION;
        mabs = 1'h0;
        mtgt = 32'h0ffffffa;
        pulse(ms);
        check("rel_fit", {pos[30:0], refv}, 32'hb);
        mtgt = 32'h0ffffffb;
        pulse(ms);
        check("rel_over", {pos[30:0], refv}, 32'h0);
    endtask : t_moves

    task automatic t_hw();
        logic e;
        bus(1'h1, `ADDR_NEGATIVE_HW_LIMIT_INPUT_CFG, 32'h0);
        nc = 1'h0;
        moving = 1'h1;
        dir = 1'h1;
        for (int c = 0; c < 3; c++) begin
            bus(1'h1, `ADDR_POSITIVE_HW_LIMIT_INPUT_CFG, 32'(c));
            for (int k = 0; k < 2; k++) begin
                p_p = k[0];
                tick();
                e = (c == 1 && k == 0) || (c == 2 && k == 1);
                check("hw_hit", {hit_p, stop}, {2{e}});
            end
        end
        rd_chk("latch_hw", `ADDR_LATCHED, 32'h2);
        mode = axis_pkg::MODE_JOG;
        dir = 1'h0;
        tick();
        check("jog_out", stop, 32'h0);
        mode = axis_pkg::MODE_PROFILE_POSITION;
        bus(1'h1, `ADDR_NEGATIVE_HW_LIMIT_INPUT_CFG, 32'h2);
        check("hw_idle_n", {hit_n, stop}, 32'h0);
        n_p = 1'h1;
        tick();
        check("hw_hit_n", {hit_n, stop}, 32'h3);
        n_p = 1'h0;
        tick();
    endtask : t_hw

    task automatic t_soft();
        bus(1'h1, `ADDR_POSITIVE_HW_LIMIT_INPUT_CFG, 32'h0);
        bus(1'h1, `ADDR_SOFT_POS, 32'h0);
        bus(1'h1, `ADDR_SOFT_NEG, 32'h0);
        bus(1'h1, `ADDR_SOFT_EN, 32'h3);
        bus(1'h1, `ADDR_LATCHED, 32'hffffffff);
        check("soft_noref", soft_hit, 32'h0);
        rd_chk("latch_noref", `ADDR_LATCHED, 32'h0);
        hval = 32'h0;
        pulse(hset);
        for (int e = 0; e < 4; e++) begin
            bus(1'h1, `ADDR_SOFT_EN, 32'(e));
            for (int d = 0; d < 2; d++) begin
                dir = d[0];
                tick();
                check("soft_hit", soft_hit, d ? e[0] : e[1]);
                check("soft_stop", stop, d ? e[0] : e[1]);
            end
        end
        rd_chk("latch_soft", `ADDR_LATCHED, 32'h4);
    endtask : t_soft

    task automatic t_ref();
        moving = 1'h0;
        for (int p = 1; p < 3; p++) begin
            bus(1'h1, `ADDR_REF_POL, 32'(p));
            for (int k = 0; k < 4; k++) begin
                homing = k[1];
                r_p = k[0];
                tick();
                check("ref_sw", ref_act, k[1] && (k[0] == (p == 2)));
            end
        end
        homing = 1'h0;
    endtask : t_ref

    task automatic t_reset();
        rst = 1'h1;
        repeat (2) tick();
        rst = 1'h0;
        check("rst_ref", refv, 32'h0);
        rd_chk("rst_soft_en", `ADDR_SOFT_EN, 32'h0);
    endtask : t_reset

    initial begin
        repeat (5) tick();
        rst = 1'h0;
        t_regs();
        t_range();
        t_moves();
        t_hw();
        t_soft();
        t_ref();
        t_reset();
        results();
    end
endmodule : axis_position_limit_monitor_tb
`default_nettype wire
